//--- wdt_defs.svh
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// Counter geometry
`define WDT_CNT_W      15
`define WDT_CNT_RELOAD 15'h7FFF

// Prescaler geometry and terminal counts (ratio minus one)
`define WDT_PRE_W      7
`define WDT_PRE_TC_2   7'h01
`define WDT_PRE_TC_16  7'h0F
`define WDT_PRE_TC_128 7'h7F

// Reset values of the control bits
`define WDT_RST_UNLOCK    1'b0
`define WDT_RST_UFL_RESET 1'b0
`define WDT_RST_OSC_SRC   1'b0
`define WDT_RST_PRESCALE  1'b0

`endif

//--- wdt_pkg.sv
package wdt_pkg;

  // Activity state of the watchdog
  typedef enum logic [0:0] {
    WDT_IDLE  = 1'b0,
    WDT_COUNT = 1'b1
  } wdt_state_t;

endpackage : wdt_pkg

//--- wdt_tick_if.sv
interface wdt_tick_if;
  logic run;        // Prescaler may advance
  logic clear;      // Restart the prescaler phase
  logic sub_clk;    // CPU runs from the sub clock
  logic div_sel;    // Prescale select, 1 = 128
  logic tick;       // One-cycle prescaler output

  modport core
  (
    output run,
    output clear,
    output sub_clk,
    output div_sel,
    input  tick
  );

  modport pre
  (
    input  run,
    input  clear,
    input  sub_clk,
    input  div_sel,
    output tick
  );
endinterface : wdt_tick_if

//--- wdt_prescaler.sv
`include "wdt_defs.svh"

module wdt_prescaler
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic   core_clk_i,
  input  wire logic   srst_i,
  // Tick link to the counter
  wdt_tick_if.pre     tick_if
);

  logic [`WDT_PRE_W-1:0] phase_reg;
  logic [`WDT_PRE_W-1:0] term;

  // Division ratio: sub clock forces 2, else 16 or 128
  always_comb
  begin
    if (tick_if.sub_clk)
      term = `WDT_PRE_TC_2;
    else if (tick_if.div_sel)
      term = `WDT_PRE_TC_128;
    else
      term = `WDT_PRE_TC_16;
  end

  // Phase counter, held while frozen, cleared on restart
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i || tick_if.clear)
      phase_reg <= '0;
    else if (tick_if.run)
    begin
      if (phase_reg >= term)
        phase_reg <= '0;
      else
        phase_reg <= phase_reg + 7'h01;
    end
  end

  // Tick once per full prescaler period
  assign tick_if.tick = tick_if.run && !tick_if.clear && (phase_reg >= term);

endmodule : wdt_prescaler

//--- wdt_core.sv
`include "wdt_defs.svh"

module wdt_core
  import wdt_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  srst_i,
  // Software writes
  input  wire logic                  restart_wr_i,
  input  wire logic                  unlock_wr_i,
  input  wire logic                  unlock_data_i,
  input  wire logic                  mode_one_wr_i,
  input  wire logic                  mode_one_data_i,
  input  wire logic                  mode_two_wr_i,
  input  wire logic                  mode_two_data_i,
  input  wire logic                  control_wr_i,
  input  wire logic                  control_data_i,
  input  wire logic                  stop_req_wr_i,
  input  wire logic                  stop_req_data_i,
  // System state
  input  wire logic                  sub_clk_cpu_i,
  input  wire logic                  sysclk_select_i,
  input  wire logic                  stop_mode_i,
  input  wire logic                  wait_mode_i,
  input  wire logic                  osc_clk_pin_i,
  // Results and status
  output logic                       wdt_irq_o,
  output logic                       wdt_reset_o,
  output logic                       stop_enter_o,
  output logic                       osc_enable_o,
  output logic                       active_o,
  output logic [`WDT_CNT_W-1:0]      count_o,
  output logic                       mode_write_unlock_o,
  output logic                       wdt_underflow_reset_sel_o,
  output logic                       wdt_osc_source_sel_o,
  output logic                       wdt_prescale_sel_o
);

  ////////////////////////////////////////////////////////////////////////
  // Control bits

  wdt_state_t            state_reg;
  logic [`WDT_CNT_W-1:0] count_reg;
  logic                  unlock_reg;
  logic                  ufl_reset_reg;
  logic                  osc_src_reg;
  logic                  prescale_reg;
  logic                  osc_s1_reg;
  logic                  osc_s2_reg;
  logic                  osc_s3_reg;
  logic                  osc_level_reg;
  logic                  osc_tick;
  logic                  run;
  logic                  tick;
  logic                  underflow;

  // Write-unlock bit
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      unlock_reg <= `WDT_RST_UNLOCK;
    else if (unlock_wr_i)
      unlock_reg <= unlock_data_i;
  end

  // Underflow action: gated by unlock, can only be set
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      ufl_reset_reg <= `WDT_RST_UFL_RESET;
    else if (mode_one_wr_i && unlock_reg)
      ufl_reset_reg <= ufl_reset_reg | mode_one_data_i;
  end

  // Oscillator count source select, gated by unlock
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      osc_src_reg <= `WDT_RST_OSC_SRC;
    else if (mode_two_wr_i && unlock_reg)
      osc_src_reg <= mode_two_data_i;
  end

  // Prescale select
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      prescale_reg <= `WDT_RST_PRESCALE;
    else if (control_wr_i)
      prescale_reg <= control_data_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // System side effects

  // Stop request accepted only outside protective mode
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      stop_enter_o <= 1'b0;
    else
      stop_enter_o <= stop_req_wr_i && stop_req_data_i && !osc_src_reg;
  end

  // Oscillator enable: own select or system clock select
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      osc_enable_o <= 1'b0;
    else
      osc_enable_o <= osc_src_reg || sysclk_select_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // Oscillator pin synchroniser and edge detect

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
    end
    else
    begin
      osc_s1_reg <= osc_clk_pin_i;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
    end
  end

  // Settled oscillator level, follows only once s2 and s3 agree
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      osc_level_reg <= 1'b0;
    else if (osc_s2_reg == osc_s3_reg)
      osc_level_reg <= osc_s3_reg;
  end

  // Rising edge counted once s2 and s3 agree high
  assign osc_tick = osc_s2_reg && osc_s3_reg && !osc_level_reg;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler and count source

  wdt_tick_if tick_if ();

  // Frozen in stop and wait, both ignored in protective mode
  assign run = (state_reg == WDT_COUNT) && !restart_wr_i
               && !(stop_mode_i && !osc_src_reg)
               && !(wait_mode_i && !osc_src_reg);

  assign tick_if.run     = run && !osc_src_reg;
  assign tick_if.clear   = restart_wr_i;
  assign tick_if.sub_clk = sub_clk_cpu_i;
  assign tick_if.div_sel = prescale_reg;

  wdt_prescaler u_prescaler
  (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .tick_if    (tick_if.pre)
  );

  // Protective mode counts oscillator edges directly
  assign tick = osc_src_reg ? (run && osc_tick) : tick_if.tick;
  assign underflow = tick && (count_reg == '0);

  ////////////////////////////////////////////////////////////////////////
  // Activity state and counter

  // Idle after reset until the first restart write
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      state_reg <= WDT_IDLE;
    else if (restart_wr_i)
      state_reg <= WDT_COUNT;
  end

  // Down counter with reload on restart and underflow
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      count_reg <= `WDT_CNT_RELOAD;
    else if (restart_wr_i)
      count_reg <= `WDT_CNT_RELOAD;
    else if (tick)
      count_reg <= count_reg - 15'h0001;
  end

  // Underflow outcome pulses
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      wdt_irq_o   <= 1'b0;
      wdt_reset_o <= 1'b0;
    end
    else
    begin
      wdt_irq_o   <= underflow && !ufl_reset_reg;
      wdt_reset_o <= underflow && ufl_reset_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered status outputs

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      active_o                  <= 1'b0;
      count_o                   <= `WDT_CNT_RELOAD;
      mode_write_unlock_o       <= `WDT_RST_UNLOCK;
      wdt_underflow_reset_sel_o <= `WDT_RST_UFL_RESET;
      wdt_osc_source_sel_o      <= `WDT_RST_OSC_SRC;
      wdt_prescale_sel_o        <= `WDT_RST_PRESCALE;
    end
    else
    begin
      active_o                  <= (state_reg == WDT_COUNT);
      count_o                   <= count_reg;
      mode_write_unlock_o       <= unlock_reg;
      wdt_underflow_reset_sel_o <= ufl_reset_reg;
      wdt_osc_source_sel_o      <= osc_src_reg;
      wdt_prescale_sel_o        <= prescale_reg;
    end
  end

endmodule : wdt_core

//--- wdt_core_assertions.sv
`include "wdt_defs.svh"

module wdt_core_assertions
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic                  core_clk_i,
  input wire logic                  srst_i,
  // Writes and system state
  input wire logic                  restart_wr_i,
  input wire logic                  unlock_wr_i,
  input wire logic                  mode_one_wr_i,
  input wire logic                  mode_one_data_i,
  input wire logic                  stop_req_wr_i,
  input wire logic                  stop_req_data_i,
  input wire logic                  sysclk_select_i,
  input wire logic                  stop_mode_i,
  input wire logic                  wait_mode_i,
  // Results and status
  input wire logic                  wdt_irq_o,
  input wire logic                  wdt_reset_o,
  input wire logic                  stop_enter_o,
  input wire logic                  osc_enable_o,
  input wire logic                  active_o,
  input wire logic [`WDT_CNT_W-1:0] count_o,
  input wire logic                  mode_write_unlock_o,
  input wire logic                  wdt_underflow_reset_sel_o,
  input wire logic                  wdt_osc_source_sel_o
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking dcb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  ////////////////////////////////////////////////////////////
  // Underflow outputs
  irq_pulse_a: assert property (wdt_irq_o |=> !wdt_irq_o)
    else $error("irq pulse longer than one cycle");
  irq_action_a: assert property (wdt_irq_o |-> !wdt_underflow_reset_sel_o)
    else $error("irq with reset action");
  reset_action_a: assert property (wdt_reset_o |-> wdt_underflow_reset_sel_o)
    else $error("reset with irq action");
  action_sticky_a: assert property (wdt_underflow_reset_sel_o |=> wdt_underflow_reset_sel_o)
    else $error("action bit cleared");
  // Counter behaviour
  idle_hold_a: assert property (!active_o |-> count_o == 15'h7FFF)
    else $error("counter moved while idle");
  restart_load_a: assert property (restart_wr_i |-> ##2 count_o == 15'h7FFF)
    else $error("restart did not reload");
  freeze_a: assert property ((!wdt_osc_source_sel_o && !restart_wr_i && (stop_mode_i || wait_mode_i))[*3]
    |-> $stable(count_o))
    else $error("counter moved while frozen");
  // Protection
  locked_write_a: assert property (mode_one_wr_i && mode_one_data_i && !mode_write_unlock_o
    && !$past(unlock_wr_i) && !wdt_underflow_reset_sel_o |-> ##2 !wdt_underflow_reset_sel_o)
    else $error("locked mode write took effect");
  stop_refused_a: assert property (stop_req_wr_i && stop_req_data_i && wdt_osc_source_sel_o
    |=> !stop_enter_o)
    else $error("stop entered in protective mode");
  osc_on_a: assert property (osc_enable_o == (wdt_osc_source_sel_o || $past(sysclk_select_i)))
    else $error("oscillator enable wrong");

  // Main scenarios
  irq_c: cover property (wdt_irq_o);
  stop_c: cover property (stop_enter_o);
  prot_wait_c: cover property (wait_mode_i && wdt_osc_source_sel_o && $changed(count_o));
endmodule : wdt_core_assertions

bind wdt_core wdt_core_assertions chk (.*);

//--- tb_top.sv
`include "wdt_defs.svh"

module tb_top
  import wdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk_i, srst_i, sub_clk_cpu_i, sysclk_select_i, stop_mode_i, wait_mode_i, osc_clk_pin_i;
  logic [5:0] we, wd;
  wire  restart_wr_i, unlock_wr_i, mode_one_wr_i, mode_two_wr_i, control_wr_i, stop_req_wr_i;
  wire  unlock_data_i, mode_one_data_i, mode_two_data_i, control_data_i, stop_req_data_i;
  logic wdt_irq_o, wdt_reset_o, stop_enter_o, osc_enable_o, active_o;
  logic mode_write_unlock_o, wdt_underflow_reset_sel_o, wdt_osc_source_sel_o, wdt_prescale_sel_o;
  logic [`WDT_CNT_W-1:0] count_o, c0;
  int   errors, n_checks, cyc, n;

  // Strobe and data vectors onto the write ports
  assign {stop_req_wr_i, control_wr_i, mode_two_wr_i, mode_one_wr_i, unlock_wr_i, restart_wr_i} = we;
  assign {stop_req_data_i, control_data_i, mode_two_data_i, mode_one_data_i, unlock_data_i} = wd[5:1];

  wdt_core DUT (.*);

  ////////////////////////////////////////////////////////////
  // Compare, write and wait helpers
  task chk(input logic [14:0] g, input logic [14:0] e);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk

  task chk_b(input logic g, input logic e);
    chk({14'h0000, g}, {14'h0000, e});
  endtask : chk_b

  // One-cycle write pulse; index 0 restart .. 5 stop request
  task wr(input int k, input logic d);
    @(negedge core_clk_i);
    we[k] = 1'b1;
    wd[k] = d;
    @(negedge core_clk_i);
    we[k] = 1'b0;
  endtask : wr

  task step(input int c);
    repeat (c) @(negedge core_clk_i);
  endtask : step

  task finish_test;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      errors++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    {srst_i, we, wd} = {1'b1, 12'h000};
    {sub_clk_cpu_i, sysclk_select_i, stop_mode_i, wait_mode_i, osc_clk_pin_i} = 5'h00;
    step(6);
    srst_i = 1'b0;
    step(40);
    chk(count_o, 15'h7FFF);
    chk_b(active_o, 1'b0);
    chk_b(osc_enable_o, 1'b0);
    sysclk_select_i = 1'b1;
    step(3);
    chk_b(osc_enable_o, 1'b1);
    sysclk_select_i = 1'b0;
    wr(2, 1'b1);
    wr(3, 1'b1);
    step(3);
    chk_b(wdt_underflow_reset_sel_o, 1'b0);
    chk_b(wdt_osc_source_sel_o, 1'b0);
    $display("idle and lock test done");
    // Divide rates /16 then /128
    wr(0, 1'b0);
    step(3);
    chk_b(active_o, 1'b1);
    c0 = count_o;
    step(160);
    chk(c0 - count_o, 15'h000A);
    wr(4, 1'b1);
    step(200);
    chk_b(wdt_prescale_sel_o, 1'b1);
    c0 = count_o;
    step(1280);
    chk(c0 - count_o, 15'h000A);
    $display("prescale test done");
    // Stop then wait freeze the count
    for (int m = 0; m < 2; m++)
    begin
      {stop_mode_i, wait_mode_i} = (m == 0) ? 2'b10 : 2'b01;
      step(3);
      c0 = count_o;
      step(300);
      chk(count_o, c0);
      {stop_mode_i, wait_mode_i} = 2'b00;
      step(300);
      chk_b(count_o < c0, 1'b1);
    end
    wr(0, 1'b1);
    step(1);
    chk(count_o, 15'h7FFF);
    wr(5, 1'b1);
    chk_b(stop_enter_o, 1'b1);
    $display("freeze and restart test done");
    // Sub clock underflow into an interrupt
    sub_clk_cpu_i = 1'b1;
    wr(0, 1'b0);
    n = 0;
    while (wdt_irq_o !== 1'b1 && n < 70000)
    begin
      @(negedge core_clk_i);
      n++;
    end
    chk_b(wdt_irq_o, 1'b1);
    chk_b(wdt_reset_o, 1'b0);
    chk_b(n >= 65530 && n <= 65545, 1'b1);
    step(1);
    chk_b(wdt_irq_o, 1'b0);
    wr(0, 1'b0);
    sub_clk_cpu_i = 1'b0;
    $display("underflow test done");
    // Protective mode entry and behaviour
    wr(1, 1'b1);
    wr(2, 1'b1);
    wr(3, 1'b1);
    wr(1, 1'b0);
    wr(0, 1'b0);
    step(3);
    chk_b(wdt_underflow_reset_sel_o, 1'b1);
    chk_b(wdt_osc_source_sel_o, 1'b1);
    chk_b(osc_enable_o, 1'b1);
    wr(1, 1'b1);
    wr(2, 1'b0);
    chk_b(mode_write_unlock_o, 1'b1);
    wr(1, 1'b0);
    step(3);
    chk_b(wdt_underflow_reset_sel_o, 1'b1);
    wr(5, 1'b1);
    chk_b(stop_enter_o, 1'b0);
    {stop_mode_i, wait_mode_i} = 2'b11;
    step(4);
    c0 = count_o;
    repeat (20)
    begin
      osc_clk_pin_i = 1'b1;
      step(2);
      osc_clk_pin_i = 1'b0;
      step(2);
    end
    step(8);
    chk(c0 - count_o, 15'h0014);
    $display("protective test done");
    finish_test();
  end
endmodule : tb_top
